// *** rtl/servo_protect.sv ***
// Overload protection and servo-off stop sequencing of a servo drive
`timescale 1ns/100ps
`default_nettype none
`include "servo_protect_map.svh"
module servo_protect #(
  parameter int unsigned MS_CYCLES = `MS_CYCLES,
  parameter int unsigned TICK_MS   = 1
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Register port
  input  wire logic [15:0] reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // Drive state
  input  wire logic        servo_on_command,
  input  wire logic [15:0] torque_feedback_pct,
  input  wire logic        motor_stopped,
  input  wire logic        torque_mode,
  input  wire logic        positive_limit_input,
  input  wire logic        negative_limit_input,
  // Power stage and brakes
  output logic             pwm_enable,
  output logic             holding_brake,
  output logic             dynamic_brake,
  output logic             ext_resistor_sel,
  output logic [15:0]      regen_ohms,
  output logic [15:0]      regen_watts,
  output logic [15:0]      regen_peak_watts,
  output logic [15:0]      regen_peak_ms,
  // Protection flags
  output logic             overload_warning,
  output logic             continuous_overload_alarm,
  output logic             irq
);
  overload_if ovl ();

  logic [15:0] res_sel_ff;
  logic [15:0] ext_resistor_ohms_ff;
  logic [15:0] ext_resistor_watts_ff;
  logic [15:0] ext_resistor_peak_watts_ff;
  logic [15:0] peak_power_duration_ms_ff;
  logic [15:0] overload_base_level_ff;
  logic [15:0] overload_warn_level_ff;
  logic [15:0] output_off_delay_ms_ff;
  logic [15:0] stop_brake_mode_ff;
  logic [2:0]  irq_status_ff;
  logic [2:0]  irq_mask_ff;
  logic [15:0] rdata_ff;
  logic [31:0] ms_cnt_ff;
  logic [15:0] delay_cnt_ff;
  logic        servo_on_d_ff;
  logic        warn_d_ff;
  logic        alarm_d_ff;
  servo_protect_pkg::stop_state_e state_ff;
  servo_protect_pkg::stop_state_e nxt_state;
  servo_protect_pkg::stop_mode_e  mode_ff;
  servo_protect_pkg::stop_mode_e  nxt_mode;

  // Writes out of range are clamped so the logic never sees an illegal value
  function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo,
                                        input logic [15:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp

  function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
    hit = (a == off);
  endfunction : hit

  wire logic wr_sel   = reg_wr && hit(reg_addr, `ADDR_RES_SELECT);
  wire logic wr_ohm   = reg_wr && hit(reg_addr, `ADDR_EXT_OHMS);
  wire logic wr_wat   = reg_wr && hit(reg_addr, `ADDR_EXT_WATTS);
  wire logic wr_pk    = reg_wr && hit(reg_addr, `ADDR_EXT_PEAK_WATTS);
  wire logic wr_dur   = reg_wr && hit(reg_addr, `ADDR_PEAK_DUR_MS);
  wire logic wr_base  = reg_wr && hit(reg_addr, `ADDR_OVL_BASE);
  wire logic wr_warn  = reg_wr && hit(reg_addr, `ADDR_OVL_WARN);
  wire logic wr_dly   = reg_wr && hit(reg_addr, `ADDR_OFF_DELAY_MS);
  wire logic wr_mode  = reg_wr && hit(reg_addr, `ADDR_STOP_MODE);
  wire logic wr_mask  = reg_wr && hit(reg_addr, `ADDR_IRQ_MASK);
  wire logic rd_stat  = reg_rd && hit(reg_addr, `ADDR_IRQ_STATUS);
  wire logic ext_sel  = res_sel_ff[0];

  always_ff @(posedge clk) begin
    if (rst) begin
      res_sel_ff                 <= `RST_RES_SELECT;
      ext_resistor_ohms_ff       <= `RST_EXT_OHMS;
      ext_resistor_watts_ff      <= `RST_EXT_WATTS;
      ext_resistor_peak_watts_ff <= `RST_EXT_PEAK_WATTS;
      peak_power_duration_ms_ff  <= `RST_PEAK_DUR_MS;
      overload_base_level_ff     <= `RST_OVL_BASE;
      overload_warn_level_ff     <= `RST_OVL_WARN;
      output_off_delay_ms_ff     <= `RST_OFF_DELAY_MS;
      stop_brake_mode_ff         <= `RST_STOP_MODE;
      irq_mask_ff                <= 3'h0;
    end else begin
      if (wr_sel)  res_sel_ff <= {15'h0000, reg_wdata[0]};
      if (wr_ohm)  ext_resistor_ohms_ff <= clamp(reg_wdata, 16'h0000, `MAX_EXT_OHMS);
      if (wr_wat)  ext_resistor_watts_ff <= clamp(reg_wdata, 16'h0000, `MAX_EXT_WATTS);
      if (wr_pk)   ext_resistor_peak_watts_ff <=
                     clamp(reg_wdata, 16'h0001, `MAX_PEAK_WATTS);
      if (wr_dur)  peak_power_duration_ms_ff <=
                     clamp(reg_wdata, 16'h0001, `MAX_PEAK_DUR_MS);
      if (wr_base) overload_base_level_ff <= clamp(reg_wdata, `MIN_OVL_BASE, `MAX_OVL_BASE);
      if (wr_warn) overload_warn_level_ff <= clamp(reg_wdata, `MIN_OVL_WARN, `MAX_OVL_WARN);
      if (wr_dly)  output_off_delay_ms_ff <= clamp(reg_wdata, 16'h0000, `MAX_OFF_DELAY_MS);
      if (wr_mode) stop_brake_mode_ff <= clamp(reg_wdata, 16'h0000, `MAX_STOP_MODE);
      if (wr_mask) irq_mask_ff <= reg_wdata[2:0];
    end
  end

  // External figures reach the regeneration logic only when selected
  assign ext_resistor_sel = ext_sel;
  assign regen_ohms       = ext_sel ? ext_resistor_ohms_ff       : 16'h0000;
  assign regen_watts      = ext_sel ? ext_resistor_watts_ff      : 16'h0000;
  assign regen_peak_watts = ext_sel ? ext_resistor_peak_watts_ff : 16'h0000;
  assign regen_peak_ms    = ext_sel ? peak_power_duration_ms_ff  : 16'h0000;

  // Millisecond time base shared by overload and off delay
  wire logic [31:0] tick_len = 32'(MS_CYCLES) * 32'(TICK_MS);
  wire logic        ms_tick  = (ms_cnt_ff == tick_len - 32'd1);
  always_ff @(posedge clk) begin
    if (rst) ms_cnt_ff <= 32'h0000_0000;
    else     ms_cnt_ff <= ms_tick ? 32'h0000_0000 : ms_cnt_ff + 32'd1;
  end

  // Torque in percent, accumulator in tenths of percent per millisecond
  assign ovl.tick       = ms_tick;
  assign ovl.torque_pct = torque_feedback_pct;
  assign ovl.base_pct   = overload_base_level_ff;
  assign ovl.warn_pct   = overload_warn_level_ff;

  overload_accum #(
    .ACC_W (32)
  ) u_accum (
    .clk (clk),
    .rst (rst),
    .ovl (ovl)
  );

  assign overload_warning          = ovl.warn;
  assign continuous_overload_alarm = ovl.alarm;

  // Stop mode; travel limit in torque mode forces a release variant
  wire logic limit_hit = positive_limit_input || negative_limit_input;
  wire servo_protect_pkg::stop_mode_e cfg_mode =
    servo_protect_pkg::stop_mode_e'(stop_brake_mode_ff[1:0]);
  always_comb begin
    nxt_mode = cfg_mode;
    if (torque_mode && limit_hit) begin
      case (cfg_mode)
        servo_protect_pkg::BRAKED_HOLD: nxt_mode = servo_protect_pkg::BRAKED_RELEASE;
        servo_protect_pkg::COAST_HOLD:  nxt_mode = servo_protect_pkg::COAST_RELEASE;
        default:                          nxt_mode = cfg_mode;
      endcase
    end
  end

  // A limit in torque mode or an alarm stops the drive like a servo off
  wire logic run_req  = servo_on_command && !ovl.alarm && !(torque_mode && limit_hit);
  wire logic dly_done = (delay_cnt_ff == 16'h0000);
  // One extra tick so the free-running tick phase never cuts the delay short
  wire logic [15:0] dly_load = (output_off_delay_ms_ff == 16'h0000) ? 16'h0000 :
                               output_off_delay_ms_ff + 16'h0001;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      servo_protect_pkg::ST_RUN:       if (!run_req) nxt_state = servo_protect_pkg::ST_OFF_DELAY;
      servo_protect_pkg::ST_OFF_DELAY: begin
        if (run_req) nxt_state = servo_protect_pkg::ST_RUN;
        else if (dly_done) nxt_state = servo_protect_pkg::ST_STOPPING;
      end
      servo_protect_pkg::ST_STOPPING: begin
        if (run_req) nxt_state = servo_protect_pkg::ST_RUN;
        else if (motor_stopped) nxt_state = servo_protect_pkg::ST_STOPPED;
      end
      servo_protect_pkg::ST_STOPPED:   if (run_req) nxt_state = servo_protect_pkg::ST_RUN;
      default:                         nxt_state = servo_protect_pkg::ST_STOPPED;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff      <= servo_protect_pkg::ST_STOPPED;
      mode_ff       <= servo_protect_pkg::BRAKED_HOLD;
      delay_cnt_ff  <= 16'h0000;
      servo_on_d_ff <= 1'b0;
    end else begin
      state_ff      <= nxt_state;
      servo_on_d_ff <= run_req;
      if (state_ff == servo_protect_pkg::ST_RUN) begin
        mode_ff      <= nxt_mode;
        delay_cnt_ff <= dly_load;
      end else if (state_ff == servo_protect_pkg::ST_OFF_DELAY && ms_tick && !dly_done) begin
        delay_cnt_ff <= delay_cnt_ff - 16'h0001;
      end
    end
  end

  wire logic in_run   = (state_ff == servo_protect_pkg::ST_RUN);
  wire logic in_delay = (state_ff == servo_protect_pkg::ST_OFF_DELAY);
  wire logic in_stop  = (state_ff == servo_protect_pkg::ST_STOPPING);
  wire logic brk_stop = (mode_ff == servo_protect_pkg::BRAKED_HOLD) ||
                        (mode_ff == servo_protect_pkg::BRAKED_RELEASE);
  wire logic brk_hold = (mode_ff == servo_protect_pkg::BRAKED_HOLD) ||
                        (mode_ff == servo_protect_pkg::COAST_HOLD);

  // Brake engages at once, PWM stays on through the delay so both overlap
  assign pwm_enable    = in_run || in_delay;
  assign holding_brake = !in_run;
  assign dynamic_brake = (in_stop && brk_stop) ||
                         ((state_ff == servo_protect_pkg::ST_STOPPED) && brk_hold);

  // Sticky events; set wins over a clearing read
  wire logic [2:0] ev;
  assign ev[`IRQ_BIT_WARN]     = ovl.warn && !warn_d_ff;
  assign ev[`IRQ_BIT_ALARM]    = ovl.alarm && !alarm_d_ff;
  assign ev[`IRQ_BIT_OFF_DONE] = in_delay && (nxt_state == servo_protect_pkg::ST_STOPPING);
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_status_ff <= 3'h0;
      warn_d_ff     <= 1'b0;
      alarm_d_ff    <= 1'b0;
    end else begin
      irq_status_ff <= (rd_stat ? 3'h0 : irq_status_ff) | ev;
      warn_d_ff     <= ovl.warn;
      alarm_d_ff    <= ovl.alarm;
    end
  end
  assign irq = |(irq_status_ff & irq_mask_ff);

  // Read mux, data registered for the next cycle
  logic [15:0] rd_mux;
  always_comb begin
    case (reg_addr)
      `ADDR_RES_SELECT:     rd_mux = res_sel_ff;
      `ADDR_EXT_OHMS:       rd_mux = ext_resistor_ohms_ff;
      `ADDR_EXT_WATTS:      rd_mux = ext_resistor_watts_ff;
      `ADDR_EXT_PEAK_WATTS: rd_mux = ext_resistor_peak_watts_ff;
      `ADDR_PEAK_DUR_MS:    rd_mux = peak_power_duration_ms_ff;
      `ADDR_OVL_BASE:       rd_mux = overload_base_level_ff;
      `ADDR_OVL_WARN:       rd_mux = overload_warn_level_ff;
      `ADDR_OFF_DELAY_MS:   rd_mux = output_off_delay_ms_ff;
      `ADDR_STOP_MODE:      rd_mux = stop_brake_mode_ff;
      `ADDR_IRQ_STATUS:     rd_mux = {13'h0000, irq_status_ff};
      `ADDR_IRQ_MASK:       rd_mux = {13'h0000, irq_mask_ff};
      `ADDR_OVL_ACC:        rd_mux = ovl.acc[15:0];
      `ADDR_DRIVE_STATUS:   rd_mux = {9'h000, mode_ff, servo_on_d_ff, pwm_enable,
                                      holding_brake, dynamic_brake, ovl.alarm};
      `ADDR_RES_ACTIVE:     rd_mux = {15'h0000, ext_sel};
      default:              rd_mux = 16'h0000;
    endcase
  end
  always_ff @(posedge clk) begin
    if (rst)         rdata_ff <= 16'h0000;
    else if (reg_rd) rdata_ff <= rd_mux;
    else             rdata_ff <= 16'h0000;
  end
  assign reg_rdata = rdata_ff;
endmodule : servo_protect
`default_nettype wire

// *** rtl/servo_protect_map.svh ***
// Register offsets, reset values and timing counts of the servo protection block
`ifndef SERVO_PROTECT_MAP_SVH
`define SERVO_PROTECT_MAP_SVH

`define ADDR_RES_SELECT      16'h2009
`define ADDR_EXT_OHMS        16'h200b
`define ADDR_EXT_WATTS       16'h200c
`define ADDR_EXT_PEAK_WATTS  16'h200d
`define ADDR_PEAK_DUR_MS     16'h200e
`define ADDR_OVL_BASE        16'h200f
`define ADDR_OVL_WARN        16'h2010
`define ADDR_OFF_DELAY_MS    16'h2011
`define ADDR_STOP_MODE       16'h2012
`define ADDR_IRQ_STATUS      16'h2020
`define ADDR_IRQ_MASK        16'h2021
`define ADDR_OVL_ACC         16'h2022
`define ADDR_DRIVE_STATUS    16'h2023
`define ADDR_RES_ACTIVE      16'h2024

`define RST_RES_SELECT       16'h0000
`define RST_EXT_OHMS         16'h0000
`define RST_EXT_WATTS        16'h0000
`define RST_EXT_PEAK_WATTS   16'h0064
`define RST_PEAK_DUR_MS      16'h1388
`define RST_OVL_BASE         16'h0064
`define RST_OVL_WARN         16'h0032
`define RST_OFF_DELAY_MS     16'h000a
`define RST_STOP_MODE        16'h0000

`define MAX_EXT_OHMS         16'h03e8
`define MAX_EXT_WATTS        16'h7530
`define MAX_PEAK_WATTS       16'hc350
`define MAX_PEAK_DUR_MS      16'hc350
`define MIN_OVL_BASE         16'h000a
`define MAX_OVL_BASE         16'h0078
`define MIN_OVL_WARN         16'h000a
`define MAX_OVL_WARN         16'h0064
`define MAX_OFF_DELAY_MS     16'h03e8
`define MAX_STOP_MODE        16'h0003

`define IRQ_BIT_WARN         0
`define IRQ_BIT_ALARM        1
`define IRQ_BIT_OFF_DONE     2

// One millisecond at the 20 MHz clock
`define CLK_HZ               20000000
`define MS_CYCLES            (`CLK_HZ / 1000)
// Percent steps in 0.1 %
`define ACC_FULL_SCALE       32'd1000

`endif

// *** rtl/servo_protect_pkg.sv ***
// Types of the servo protection block
`default_nettype none
package servo_protect_pkg;
  typedef enum logic [1:0] {
    BRAKED_HOLD,
    BRAKED_RELEASE,
    COAST_RELEASE,
    COAST_HOLD
  } stop_mode_e;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_OFF_DELAY,
    ST_STOPPING,
    ST_STOPPED
  } stop_state_e;
endpackage : servo_protect_pkg
`default_nettype wire

// *** rtl/overload_if.sv ***
// Signals between the protection top and the overload accumulator
`timescale 1ns/100ps
`default_nettype none
interface overload_if;
  logic        tick;
  logic [15:0] torque_pct;
  logic [15:0] base_pct;
  logic [15:0] warn_pct;
  logic [31:0] acc;
  logic        warn;
  logic        alarm;
  modport top (output tick, output torque_pct, output base_pct, output warn_pct,
               input acc, input warn, input alarm);
  modport acc_side (input tick, input torque_pct, input base_pct, input warn_pct,
                    output acc, output warn, output alarm);
endinterface : overload_if
`default_nettype wire

// *** rtl/overload_accum.sv ***
// Continuous overload accumulator with warning and alarm thresholds
`timescale 1ns/100ps
`default_nettype none
`include "servo_protect_map.svh"
module overload_accum #(
  parameter int ACC_W = 32
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Link to the top
  overload_if.acc_side    ovl
);
  logic [ACC_W-1:0] acc_ff;
  logic [ACC_W-1:0] nxt_acc;
  logic             alarm_ff;
  logic             nxt_alarm;
  wire logic        above = ovl.torque_pct > ovl.base_pct;
  wire logic [ACC_W-1:0] excess = ACC_W'(ovl.torque_pct - ovl.base_pct);
  wire logic [ACC_W-1:0] full = ACC_W'(`ACC_FULL_SCALE);
  wire logic [ACC_W-1:0] warn_lvl = ACC_W'(ovl.warn_pct) * ACC_W'(10);

  // Accumulate only above base, decay below it, clamp at zero and full scale
  assign nxt_acc = !ovl.tick ? acc_ff :
                   above ? ((acc_ff + excess >= full) ? full : acc_ff + excess) :
                   (ovl.torque_pct < ovl.base_pct) ? ((acc_ff == '0) ? '0 : acc_ff - 1'b1) :
                   acc_ff;
  // Alarm latches until reset; a drive alarm needs a reset to clear
  assign nxt_alarm = alarm_ff | (nxt_acc >= full);

  always_ff @(posedge clk) begin
    if (rst) begin
      acc_ff   <= '0;
      alarm_ff <= 1'b0;
    end else begin
      acc_ff   <= nxt_acc;
      alarm_ff <= nxt_alarm;
    end
  end

  assign ovl.acc   = acc_ff;
  assign ovl.alarm = alarm_ff;
  assign ovl.warn  = (acc_ff >= warn_lvl) && !alarm_ff;
endmodule : overload_accum
`default_nettype wire

// *** tb/servo_protect_chk.sv ***
// Port-level assertions for the servo protection block
`timescale 1ns/100ps
`default_nettype none
module servo_protect_chk (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Drive state
  input wire logic        servo_on_command,
  input wire logic        torque_mode,
  input wire logic        positive_limit_input,
  // Power stage and resistor
  input wire logic        pwm_enable,
  input wire logic        holding_brake,
  input wire logic        dynamic_brake,
  input wire logic        ext_resistor_sel,
  input wire logic [15:0] regen_ohms,
  input wire logic [15:0] regen_watts,
  // Protection flags
  input wire logic        overload_warning,
  input wire logic        continuous_overload_alarm
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_pwm_after_brake: assert property (
    $fell(pwm_enable) |-> holding_brake && $past(holding_brake))
    else $error("pwm went off before the holding brake");
  a_brake_overlap: assert property (
    $rose(holding_brake) |-> pwm_enable)
    else $error("brake engaged without pwm overlap");
  a_run_no_brakes: assert property (
    !holding_brake |-> pwm_enable && !dynamic_brake)
    else $error("brake applied while running");
  a_servo_off_brake: assert property (
    $fell(servo_on_command) && !holding_brake |-> ##[1:2] holding_brake)
    else $error("servo off did not engage the brake");
  a_limit_stops: assert property (
    torque_mode && positive_limit_input && !holding_brake |-> ##[1:2] holding_brake)
    else $error("travel limit in torque mode did not stop");
  a_alarm_stops: assert property (
    $rose(continuous_overload_alarm) |-> ##[0:2] holding_brake)
    else $error("alarm did not start the stop");
  a_alarm_sticky: assert property (
    continuous_overload_alarm |=> continuous_overload_alarm)
    else $error("alarm cleared without reset");
  a_warn_yields: assert property (
    continuous_overload_alarm |-> !overload_warning)
    else $error("warning stands beside the alarm");
  a_regen_gated: assert property (
    !ext_resistor_sel |-> regen_ohms == 16'h0000 && regen_watts == 16'h0000)
    else $error("external resistor values used while internal selected");
endmodule : servo_protect_chk

bind servo_protect servo_protect_chk i_servo_protect_chk (
  .clk(clk), .rst(rst), .servo_on_command(servo_on_command),
  .torque_mode(torque_mode), .positive_limit_input(positive_limit_input),
  .pwm_enable(pwm_enable), .holding_brake(holding_brake), .dynamic_brake(dynamic_brake),
  .ext_resistor_sel(ext_resistor_sel), .regen_ohms(regen_ohms), .regen_watts(regen_watts),
  .overload_warning(overload_warning), .continuous_overload_alarm(continuous_overload_alarm));
`default_nettype wire

// *** tb/power_stage_model.sv ***
// Shaft model on the power-stage side of the drive
`timescale 1ns/100ps
`default_nettype none
module power_stage_model #(
  parameter int COAST_CYC = 12
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // From the drive
  input wire logic pwm_enable,
  input wire logic dynamic_brake,
  // To the drive
  output logic     motor_stopped
);
  int spin_ff;
  // Braked shaft stops about three times sooner than a coasting one
  always_ff @(posedge clk) begin
    if (rst || pwm_enable) spin_ff <= COAST_CYC;
    else if (spin_ff != 0) spin_ff <= spin_ff - ((dynamic_brake && spin_ff > 2) ? 3 : 1);
  end
  assign motor_stopped = (spin_ff == 0) && !pwm_enable;
endmodule : power_stage_model
`default_nettype wire

// *** tb/servo_protect_tb.sv ***
// Self-checking bench of the servo protection block
`timescale 1ns/100ps
`default_nettype none
`include "servo_protect_map.svh"
module servo_protect_tb;
  logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [15:0] reg_addr = 16'h0000, reg_wdata = 16'h0000, torque_feedback_pct = 16'h0000;
  logic servo_on_command = 1'b0, torque_mode = 1'b0;
  logic positive_limit_input = 1'b0, negative_limit_input = 1'b0;
  logic [15:0] reg_rdata, regen_ohms, regen_watts, regen_peak_watts, regen_peak_ms;
  logic pwm_enable, holding_brake, dynamic_brake, ext_resistor_sel, motor_stopped;
  logic overload_warning, continuous_overload_alarm, irq;
  int failures = 0;
  int cmp_count = 0;
  logic [15:0] addrs [9] = '{`ADDR_RES_SELECT, `ADDR_EXT_OHMS, `ADDR_EXT_WATTS,
    `ADDR_EXT_PEAK_WATTS, `ADDR_PEAK_DUR_MS, `ADDR_OVL_BASE, `ADDR_OVL_WARN,
    `ADDR_OFF_DELAY_MS, `ADDR_STOP_MODE};
  logic [15:0] rstv [9] = '{16'h0000, 16'h0000, 16'h0000, 16'h0064, 16'h1388,
    16'h0064, 16'h0032, 16'h000a, 16'h0000};

  always #25 clk = ~clk;

  // A short millisecond keeps the stop and overload counts small
  servo_protect #(.MS_CYCLES(4)) i_servo_protect (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .servo_on_command(servo_on_command),
    .torque_feedback_pct(torque_feedback_pct), .motor_stopped(motor_stopped),
    .torque_mode(torque_mode), .positive_limit_input(positive_limit_input),
    .negative_limit_input(negative_limit_input), .pwm_enable(pwm_enable),
    .holding_brake(holding_brake), .dynamic_brake(dynamic_brake),
    .ext_resistor_sel(ext_resistor_sel), .regen_ohms(regen_ohms), .regen_watts(regen_watts),
    .regen_peak_watts(regen_peak_watts), .regen_peak_ms(regen_peak_ms),
    .overload_warning(overload_warning), .continuous_overload_alarm(continuous_overload_alarm),
    .irq(irq));

  power_stage_model i_power_stage_model (.clk(clk), .rst(rst), .pwm_enable(pwm_enable),
    .dynamic_brake(dynamic_brake), .motor_stopped(motor_stopped));

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  function automatic logic pick(input int w);
    case (w)
      0: return pwm_enable;
      1: return motor_stopped;
      2: return overload_warning;
      default: return continuous_overload_alarm;
    endcase
  endfunction : pick

  // Bounded wait so a stuck output ends as a mismatch, not a hang
  task automatic wait_for(input int w, input logic lvl, output int n);
    for (n = 0; n < 400 && pick(w) !== lvl; n++) begin
      @(posedge clk);
      #1;
    end
    chk("wait_bound", 16'(n < 400), 16'h0001);
  endtask : wait_for

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    report_and_stop();
  end

  initial begin
    int n;
    logic [15:0] d, a1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      rd(addrs[i], d);
      chk("reset_value", d, rstv[i]);
    end
    rd(16'h2015, d);
    chk("unmapped_read", d, 16'h0000);
    wr(`ADDR_EXT_OHMS, 16'h07d0);
    rd(`ADDR_EXT_OHMS, d);
    chk("ohms_clamp", d, 16'h03e8);
    chk("ohms_ignored", regen_ohms, 16'h0000);
    wr(`ADDR_EXT_WATTS, 16'h7530);
    wr(`ADDR_EXT_PEAK_WATTS, 16'hc350);
    wr(`ADDR_PEAK_DUR_MS, 16'h0001);
    wr(`ADDR_RES_SELECT, 16'h0001);
    @(posedge clk);
    #1;
    chk("ext_select", 16'(ext_resistor_sel), 16'h0001);
    chk("ext_ohms", regen_ohms, 16'h03e8);
    chk("ext_watts", regen_watts, 16'h7530);
    chk("ext_peak", regen_peak_watts, 16'hc350);
    chk("ext_peak_ms", regen_peak_ms, 16'h0001);
    wr(`ADDR_RES_SELECT, 16'h0000);
    @(posedge clk);
    #1;
    chk("int_peak", regen_peak_watts, 16'h0000);
    $display("test registers done");
    wr(`ADDR_OFF_DELAY_MS, 16'h0002);
    for (int m = 0; m < 4; m++) begin
      if (m == 3) wr(`ADDR_OFF_DELAY_MS, 16'h0000);
      wr(`ADDR_STOP_MODE, 16'(m));
      @(posedge clk);
      servo_on_command <= 1'b1;
      wait_for(0, 1'b1, n);
      repeat (3) @(posedge clk);
      servo_on_command <= 1'b0;
      if (m != 3) begin
        repeat (2) @(posedge clk);
        #1;
        chk("brake_overlap", {14'h0, holding_brake, pwm_enable}, 16'h0003);
      end
      wait_for(0, 1'b0, n);
      chk("off_delay", 16'((m == 3) ? (n <= 4) : (n >= 7 && n <= 12)), 16'h0001);
      chk("stop_brake", 16'(dynamic_brake), 16'(m < 2));
      wait_for(1, 1'b1, n);
      repeat (2) @(posedge clk);
      #1;
      chk("hold_brake", 16'(dynamic_brake), 16'(m == 0 || m == 3));
    end
    $display("test stop modes done");
    wr(`ADDR_OFF_DELAY_MS, 16'h0001);
    wr(`ADDR_STOP_MODE, 16'h0000);
    @(posedge clk);
    torque_mode <= 1'b1;
    servo_on_command <= 1'b1;
    wait_for(0, 1'b1, n);
    @(posedge clk);
    positive_limit_input <= 1'b1;
    wait_for(0, 1'b0, n);
    chk("limit_stop", 16'(dynamic_brake), 16'h0001);
    wait_for(1, 1'b1, n);
    repeat (2) @(posedge clk);
    #1;
    chk("limit_release", 16'(dynamic_brake), 16'h0000);
    @(posedge clk);
    positive_limit_input <= 1'b0;
    torque_mode <= 1'b0;
    wait_for(0, 1'b1, n);
    @(posedge clk);
    torque_mode <= 1'b1;
    negative_limit_input <= 1'b1;
    wait_for(0, 1'b0, n);
    chk("neg_limit_stop", 16'(dynamic_brake), 16'h0001);
    @(posedge clk);
    negative_limit_input <= 1'b0;
    torque_mode <= 1'b0;
    $display("test travel limit done");
    wr(`ADDR_IRQ_MASK, 16'h0000);
    rd(`ADDR_IRQ_STATUS, d);
    wr(`ADDR_OVL_WARN, 16'h000a);
    wr(`ADDR_OVL_BASE, 16'h006e);
    @(posedge clk);
    torque_feedback_pct <= 16'd105;
    repeat (80) @(posedge clk);
    rd(`ADDR_OVL_ACC, d);
    chk("acc_below_base", d, 16'h0000);
    wr(`ADDR_OVL_BASE, 16'h0064);
    @(posedge clk);
    torque_feedback_pct <= 16'd120;
    wait_for(2, 1'b1, n);
    rd(`ADDR_OVL_ACC, d);
    chk("warn_level", 16'(d >= 16'd100 && d < 16'd140), 16'h0001);
    chk("irq_masked", 16'(irq), 16'h0000);
    wr(`ADDR_IRQ_MASK, 16'h0007);
    @(posedge clk);
    #1;
    chk("irq_unmasked", 16'(irq), 16'h0001);
    rd(`ADDR_IRQ_STATUS, d);
    chk("status_warn", d, 16'h0001);
    @(posedge clk);
    #1;
    chk("irq_cleared", 16'(irq), 16'h0000);
    @(posedge clk);
    torque_feedback_pct <= 16'd0;
    rd(`ADDR_OVL_ACC, a1);
    repeat (38) @(posedge clk);
    rd(`ADDR_OVL_ACC, d);
    chk("acc_decay", a1 - d, 16'd10);
    @(posedge clk);
    torque_feedback_pct <= 16'd120;
    wait_for(3, 1'b1, n);
    chk("warn_replaced", 16'(overload_warning), 16'h0000);
    @(posedge clk);
    #1;
    chk("irq_alarm", 16'(irq), 16'h0001);
    wait_for(0, 1'b0, n);
    chk("alarm_stop", 16'(holding_brake), 16'h0001);
    $display("test overload done");
    report_and_stop();
  end
endmodule : servo_protect_tb
`default_nettype wire
